// ===== rtl/lrc_bank.sv
// module: per-channel receive and channel control registers behind the parallel port
`timescale 1ns/100ps

// Functional notes
// - bit5 turns digital detector off, ds3/sts1
// - bit4 turns analog detector off, ds3/sts1
// - bit3 picks recovered data launch edge
// - bit2 forces data low during absence
// - bit1 selects receive monitor mode
// - bit0 enables receive equalizer
// - bits 7..6 reserved, others read/write
// - channel control loopback, rate, rail fields
module lrc_bank
    import lrc_pkg::*;
#(
    parameter int NUM_CH = 12
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rstn_in,
    // parallel microprocessor port
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic [DATA_W-1:0]   wdata_in,
    input  wire logic                cs_in,
    input  wire logic                wr_in,
    input  wire logic                rd_in,
    output logic      [DATA_W-1:0]   rdata_out,
    output logic                     rack_out,
    // front end inputs per channel
    input  wire logic [NUM_CH-1:0]   dlos_raw_in,
    input  wire logic [NUM_CH-1:0]   alos_raw_in,
    input  wire logic [NUM_CH-1:0]   rec_pos_in,
    input  wire logic [NUM_CH-1:0]   rec_neg_in,
    // system side per channel
    output logic      [NUM_CH-1:0]   rec_clk_out,
    output logic      [NUM_CH-1:0]   recovered_positive_data_out,
    output logic      [NUM_CH-1:0]   recovered_negative_data_out,
    output logic      [NUM_CH-1:0]   los_out,
    // front end controls per channel
    output logic      [NUM_CH-1:0]   dlos_det_en_out,
    output logic      [NUM_CH-1:0]   alos_det_en_out,
    output logic      [NUM_CH-1:0]   monitor_mode_out,
    output logic      [NUM_CH-1:0]   equalizer_en_out,
    output logic      [NUM_CH-1:0]   remote_loopback_select_out,
    output logic      [NUM_CH-1:0]   local_loopback_select_out,
    output logic      [NUM_CH-1:0]   european_rate_select_out,
    output logic      [NUM_CH-1:0]   sonet_or_north_american_rate_select_out,
    output logic      [NUM_CH-1:0]   single_or_dual_rail_select_out
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [3:0]              sel_ch;
    logic [3:0]              sel_off;
    logic                    ch_ok;
    logic                    hit_rx;
    logic                    hit_cc;
    logic                    wr_go;
    logic                    rd_go;
    logic [DATA_W-1:0]       rdata_d;
    logic [DATA_W-1:0]       rdata_q;
    logic                    rack_q;
    logic [NUM_CH-1:0][7:0]  rx_ctrl_q;
    logic [NUM_CH-1:0][7:0]  ch_ctrl_q;
    logic [NUM_CH-1:0]       ch_sel;
    logic [NUM_CH-1:0]       wr_rx;
    logic [NUM_CH-1:0]       wr_cc;
    logic [NUM_CH-1:0][7:0]  rx_view;
    logic [NUM_CH-1:0][7:0]  cc_view;

    // channel nibble and register offset; offsets other than the two
    // registers are left free for the neighbouring register groups
    assign sel_ch  = addr_in[CH_MSB:CH_LSB];
    assign sel_off = addr_in[OFF_MSB:OFF_LSB];
    // channel nibbles beyond the last channel are unmapped
    assign ch_ok   = (32'(sel_ch) < NUM_CH);
    assign hit_rx  = ch_ok & (sel_off == OFF_RX_CTRL);
    assign hit_cc  = ch_ok & (sel_off == OFF_CH_CTRL);
    assign wr_go   = cs_in & wr_in;
    assign rd_go   = cs_in & rd_in & ~wr_in;

    // host access rules, kept in one place so the decode stays readable:
    //  - a write is taken on every edge that sees chip select and write high;
    //    a host that holds the strobe for several cycles only rewrites the
    //    same value, so no edge detect is needed on the strobe
    //  - write wins over a simultaneous read, which keeps the read answer
    //    from showing a half-updated register
    //  - an address whose channel nibble lies beyond the last channel, or
    //    whose offset is neither register, is ignored on write and reads zero
    //  - reserved bits are masked on the way in and again on the way out,
    //    so a later change of the reset value cannot leak into them

    // ----------------------------------------------------------------
    // per-channel registers and lanes
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            lrc_cfg_if cfg ();

            // one-hot channel select keeps each write enable a plain and
            assign ch_sel[g] = (32'(sel_ch) == g);
            assign wr_rx[g]  = wr_go & hit_rx & ch_sel[g];
            assign wr_cc[g]  = wr_go & hit_cc & ch_sel[g];

            // own receive control copy per channel
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    rx_ctrl_q[g] <= RX_CTRL_RESET;
                end else if (wr_rx[g]) begin
                    rx_ctrl_q[g] <= wdata_in & RX_CTRL_WMASK;
                end
            end

            // channel control fields, own copy per channel
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    ch_ctrl_q[g] <= CH_CTRL_RESET;
                end else if (wr_cc[g]) begin
                    ch_ctrl_q[g] <= wdata_in & CH_CTRL_WMASK;
                end
            end

            // host view of the registers; reserved bits read zero
            assign rx_view[g] = rx_ctrl_q[g] & RX_CTRL_WMASK;
            assign cc_view[g] = ch_ctrl_q[g] & CH_CTRL_WMASK;

            assign cfg.rx_ctrl = rx_ctrl_q[g];
            assign cfg.ch_ctrl = ch_ctrl_q[g];

            // front end controls come straight from the register bits with
            // no retiming; the analog side treats them as static settings,
            // so a change while traffic runs may disturb a few received bits
            // monitor mode, equalizer, loopback, rate and rail selects to front end
            assign monitor_mode_out[g] = rx_ctrl_q[g][RX_MON_BIT];
            assign equalizer_en_out[g] = rx_ctrl_q[g][RX_EQ_BIT];
            assign remote_loopback_select_out[g]              = ch_ctrl_q[g][CC_RLB_BIT];
            assign local_loopback_select_out[g]               = ch_ctrl_q[g][CC_LLB_BIT];
            assign european_rate_select_out[g]                = ch_ctrl_q[g][CC_E3_BIT];
            assign sonet_or_north_american_rate_select_out[g] = ch_ctrl_q[g][CC_STS1_BIT];
            assign single_or_dual_rail_select_out[g]          = ch_ctrl_q[g][CC_SR_BIT];

            // the lane sees the registers through the interface only, so a
            // new field needs no change to the lane's port list
            lrc_rx_lane u_lane (
                .clk_in                      (clk_in),
                .rstn_in                     (rstn_in),
                .cfg                         (cfg.lane),
                .dlos_raw_in                 (dlos_raw_in[g]),
                .alos_raw_in                 (alos_raw_in[g]),
                .rec_pos_in                  (rec_pos_in[g]),
                .rec_neg_in                  (rec_neg_in[g]),
                .rec_clk_out                 (rec_clk_out[g]),
                .recovered_positive_data_out (recovered_positive_data_out[g]),
                .recovered_negative_data_out (recovered_negative_data_out[g]),
                .los_out                     (los_out[g]),
                .dlos_det_en_out             (dlos_det_en_out[g]),
                .alos_det_en_out             (alos_det_en_out[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // read mux; unmapped addresses answer with zero rather than stale data
    always_comb begin
        rdata_d = RDATA_UNMAPPED;
        if (hit_rx) begin
            // index is safe: hits are only set for channels that exist
            rdata_d = rx_view[sel_ch[3:0]];
        end else if (hit_cc) begin
            rdata_d = cc_view[sel_ch[3:0]];
        end
    end

    // read data held until the next read so slow hosts can sample late
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= RDATA_UNMAPPED;
        end else if (rd_go) begin
            rdata_q <= rdata_d;
        end
    end

    // acknowledge is a one-cycle pulse after each taken read; a host that
    // holds the read strobe for several cycles sees one pulse per cycle,
    // each carrying the same data, so it may stop at the first one
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rack_q <= 1'b0;
        end else begin
            rack_q <= rd_go;
        end
    end

    assign rdata_out = rdata_q;
    assign rack_out  = rack_q;

endmodule

// ===== rtl/lrc_pkg.sv
// package: register map, field positions and reset values of the receive control bank
package lrc_pkg;

    // ----------------------------------------------------------------
    // address layout: upper nibble selects the channel, lower the register
    // ----------------------------------------------------------------
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 8;
    localparam int         CH_MSB          = 7;
    localparam int         CH_LSB          = 4;
    localparam int         OFF_MSB         = 3;
    localparam int         OFF_LSB         = 0;
    localparam logic [3:0] OFF_RX_CTRL     = 4'h5;
    localparam logic [3:0] OFF_CH_CTRL     = 4'h6;

    // ----------------------------------------------------------------
    // receive control fields
    // ----------------------------------------------------------------
    localparam int         RX_DLOS_OFF_BIT = 5;
    localparam int         RX_ALOS_OFF_BIT = 4;
    localparam int         RX_EDGE_BIT     = 3;
    localparam int         RX_MUTE_BIT     = 2;
    localparam int         RX_MON_BIT      = 1;
    localparam int         RX_EQ_BIT       = 0;
    localparam logic [7:0] RX_CTRL_WMASK   = 8'h3f;
    localparam logic [7:0] RX_CTRL_RESET   = 8'h00;

    // ----------------------------------------------------------------
    // channel control fields
    // ----------------------------------------------------------------
    localparam int         CC_RLB_BIT      = 4;
    localparam int         CC_LLB_BIT      = 3;
    localparam int         CC_E3_BIT       = 2;
    localparam int         CC_STS1_BIT     = 1;
    localparam int         CC_SR_BIT       = 0;
    localparam logic [7:0] CH_CTRL_WMASK   = 8'h1f;
    localparam logic [7:0] CH_CTRL_RESET   = 8'h00;

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

endpackage

// ===== rtl/lrc_cfg_if.sv
// interface: one channel's control registers passed from bank to lane
`timescale 1ns/100ps
interface lrc_cfg_if;
    logic [7:0] rx_ctrl;
    logic [7:0] ch_ctrl;

    modport bank (output rx_ctrl, output ch_ctrl);
    modport lane (input rx_ctrl, input ch_ctrl);
endinterface

// ===== rtl/lrc_rx_lane.sv
// module: one channel's receive path - signal-absence qualify, mute, launch edge
`timescale 1ns/100ps
module lrc_rx_lane
    import lrc_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // control registers
    lrc_cfg_if.lane   cfg,
    // raw detector and recovered data from the analog front end
    input  wire logic dlos_raw_in,
    input  wire logic alos_raw_in,
    input  wire logic rec_pos_in,
    input  wire logic rec_neg_in,
    // system side, plus detector enables to the front end
    output logic      rec_clk_out,
    output logic      recovered_positive_data_out,
    output logic      recovered_negative_data_out,
    output logic      los_out,
    output logic      dlos_det_en_out,
    output logic      alos_det_en_out
);

    logic ds3_or_sts1;
    logic dlos_en;
    logic alos_en;
    logic phase_q;
    logic launch;
    logic mute;
    logic los_q;
    logic pos_q;
    logic neg_q;

    // ----------------------------------------------------------------
    // detector enables
    // ----------------------------------------------------------------
    // in e3 rate the off bits are ignored, so both detectors stay on
    assign ds3_or_sts1 = ~cfg.ch_ctrl[CC_E3_BIT];
    assign dlos_en     = ~(ds3_or_sts1 & cfg.rx_ctrl[RX_DLOS_OFF_BIT]);
    assign alos_en     = ~(ds3_or_sts1 & cfg.rx_ctrl[RX_ALOS_OFF_BIT]);
    assign dlos_det_en_out = dlos_en;
    assign alos_det_en_out = alos_en;

    // declared signal absence, registered so mute and status agree
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            los_q <= 1'b0;
        end else begin
            los_q <= (dlos_raw_in & dlos_en) | (alos_raw_in & alos_en);
        end
    end
    assign los_out = los_q;

    // ----------------------------------------------------------------
    // recovered clock and launch
    // ----------------------------------------------------------------
    // recovered clock is half the core rate; one domain keeps timing simple
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end
    assign rec_clk_out = phase_q;

    assign launch = cfg.rx_ctrl[RX_EDGE_BIT] ? phase_q : ~phase_q;
    assign mute   = cfg.rx_ctrl[RX_MUTE_BIT] & los_q;

    // data changes together with the selected clock transition
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (launch) begin
            pos_q <= rec_pos_in & ~mute;
            neg_q <= rec_neg_in & ~mute;
        end
    end
    assign recovered_positive_data_out = pos_q;
    assign recovered_negative_data_out = neg_q;

endmodule

// ===== test/lrc_bank_checker.sv
// checker: port-level timing and field checks of the bank
`timescale 1ns/100ps
module lrc_bank_checker
    import lrc_pkg::*;
#(
    parameter int NUM_CH = 12
) (
    input wire logic              clk_in, rstn_in, cs_in, wr_in, rd_in, rack_out,
    input wire logic [7:0]        addr_in, wdata_in, rdata_out,
    input wire logic [NUM_CH-1:0] dlos_raw_in, alos_raw_in, rec_clk_out, los_out,
    input wire logic [NUM_CH-1:0] recovered_positive_data_out, dlos_det_en_out,
    input wire logic [NUM_CH-1:0] alos_det_en_out, monitor_mode_out, equalizer_en_out,
    input wire logic [NUM_CH-1:0] remote_loopback_select_out, european_rate_select_out
);
    // launch edge bit of channel 0 as last written, rebuilt from the bus alone
    logic edge_q;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            edge_q <= 1'b0;
        end else if (cs_in && wr_in && addr_in == 8'h05) begin
            edge_q <= wdata_in[3];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // write strobe for one address; a read in the same cycle loses
    sequence s_wr(logic [7:0] a);
        cs_in && wr_in && addr_in == a;
    endsequence
    property p_rack; cs_in && rd_in && !wr_in |=> rack_out; endproperty
    a_rack: assert property (p_rack) else $error("read not acknowledged");
    property p_resv; rack_out |-> rdata_out[7:6] == 2'b00; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits read set");
    property p_rx;
        s_wr(8'h05) |=> equalizer_en_out[0] == $past(wdata_in[0])
            && monitor_mode_out[0] == $past(wdata_in[1]);
    endproperty
    a_rx: assert property (p_rx) else $error("rx control not applied");
    property p_cc;
        s_wr(8'h06) |=> remote_loopback_select_out[0] == $past(wdata_in[4])
            && european_rate_select_out[0] == $past(wdata_in[2]);
    endproperty
    a_cc: assert property (p_cc) else $error("channel control not applied");
    property p_iso; s_wr(8'h16) |=> $stable(remote_loopback_select_out[0]); endproperty
    a_iso: assert property (p_iso) else $error("channel write leaked");
    property p_e3;
        european_rate_select_out[0] |-> dlos_det_en_out[0] && alos_det_en_out[0];
    endproperty
    a_e3: assert property (p_e3) else $error("detector off in e3");
    property p_los;
        1'b1 |=> los_out[0] == $past(dlos_raw_in[0] & dlos_det_en_out[0]
            | alos_raw_in[0] & alos_det_en_out[0]);
    endproperty
    a_los: assert property (p_los) else $error("absence not qualified");
    // the release edge itself is skipped: the clock has not started there
    property p_clk; rstn_in |=> rec_clk_out[0] != $past(rec_clk_out[0]); endproperty
    a_clk: assert property (p_clk) else $error("recovered clock stalled");
    // after a data change the clock stands at the level its chosen edge leads to
    property p_data;
        $changed(recovered_positive_data_out[0]) |-> rec_clk_out[0] != $past(edge_q);
    endproperty
    a_data: assert property (p_data) else $error("data moved off clock edge");
endmodule

// ===== test/lrc_framer_model.sv
// partner: system-side framer sampling recovered data
`timescale 1ns/100ps
module lrc_framer_model (
    input  wire logic       rec_clk_in,
    input  wire logic       inv_in,
    input  wire logic       pos_in,
    input  wire logic       neg_in,
    output logic      [1:0] cap_out
);
    // sample opposite edge
    // half a period after launch, so data has settled
    always @(rec_clk_in)
        if (rec_clk_in == inv_in) cap_out <= {pos_in, neg_in};
endmodule

// ===== test/lrc_bank_bench.sv
// bench: self-checking bench for the receive control bank
`timescale 1ns/100ps
module lrc_bank_bench;
    import lrc_pkg::*;
    logic clk_in = 0, rstn_in = 0, cs = 0, wr = 0, rd = 0, inv = 0, rack;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [1:0] dl = '0, al = '0, pi = '0, ni = '0, rclk, po, no, los, den, aen;
    logic [1:0] mon, eq, rlb, llb, eu, so, sr, cap;
    int failures = 0, samples_checked = 0;
    always #2.5 clk_in = ~clk_in;
    lrc_bank #(.NUM_CH(2)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr),
        .wdata_in(wd), .cs_in(cs), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .rack_out(rack), .dlos_raw_in(dl), .alos_raw_in(al), .rec_pos_in(pi),
        .rec_neg_in(ni), .rec_clk_out(rclk), .recovered_positive_data_out(po),
        .recovered_negative_data_out(no), .los_out(los), .dlos_det_en_out(den),
        .alos_det_en_out(aen), .monitor_mode_out(mon), .equalizer_en_out(eq),
        .remote_loopback_select_out(rlb), .local_loopback_select_out(llb),
        .european_rate_select_out(eu), .sonet_or_north_american_rate_select_out(so),
        .single_or_dual_rail_select_out(sr));
    lrc_framer_model u_fr (.rec_clk_in(rclk[0]), .inv_in(inv), .pos_in(po[0]),
        .neg_in(no[0]), .cap_out(cap));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write cycle, then settle
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {cs, wr, addr, wd} <= {2'b11, a, d};
        @(posedge clk_in);
        {cs, wr} <= 2'b00;
        @(negedge clk_in);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        {cs, rd, addr} <= {2'b11, a};
        @(posedge clk_in);
        {cs, rd} <= 2'b00;
        @(negedge clk_in);
        chk({7'h00, rack}, 8'h01);
        chk(rdata, e);
    endtask
    task automatic t_regs;
        rreg(8'h05, RX_CTRL_RESET);
        rreg(8'h16, CH_CTRL_RESET);
        wreg(8'h05, 8'hff);
        chk({6'h0, mon[0], eq[0]}, 8'h03);
        rreg(8'h05, 8'h3f);
        wreg(8'h06, 8'hff);
        rreg(8'h06, 8'h1f);
        wreg(8'h06, 8'h15);
        chk({3'h0, rlb[0], llb[0], eu[0], so[0], sr[0]}, 8'h15);
        // a channel 1 write must leave channel 0 untouched
        wreg(8'h16, 8'h1f);
        chk({6'h0, rlb}, 8'h03);
        rreg(8'h06, 8'h15);
        rreg(8'h07, RDATA_UNMAPPED);
        rreg(8'h25, RDATA_UNMAPPED);
        // equalizer left on, as software normally does
        wreg(8'h05, 8'h01);
        chk({4'h0, mon, eq}, 8'h01);
        $display("test regs done");
    endtask
    task automatic t_det;
        wreg(8'h06, 8'h00);
        wreg(8'h05, 8'h31);
        chk({4'h0, den, aen}, 8'h0a);
        @(posedge clk_in);
        {dl, al} <= 4'b0101;
        repeat (2) @(negedge clk_in);
        chk({7'h0, los[0]}, 8'h00);
        wreg(8'h06, 8'h04);
        @(negedge clk_in);
        chk({6'h0, den[0], los[0]}, 8'h03);
        wreg(8'h06, 8'h00);
        wreg(8'h05, 8'h05);
        @(posedge clk_in);
        {pi, ni} <= 4'b1111;
        repeat (4) @(negedge clk_in);
        chk({5'h0, los[0], po[0], no[0]}, 8'h04);
        chk({6'h0, cap}, 8'h00);
        wreg(8'h05, 8'h01);
        repeat (4) @(negedge clk_in);
        chk({6'h0, cap}, 8'h03);
        $display("test detect and mute done");
    endtask
    // wait for a data change and note the clock level at that moment
    task automatic t_edge(input logic [7:0] rx, input logic v);
        wreg(8'h05, rx);
        inv <= rx[3];
        @(posedge clk_in);
        {dl, al, pi, ni} <= {4'b0000, 1'b0, v, 2'b00};
        @(negedge clk_in);
        for (int i = 0; i < 8 && po[0] !== v; i++) @(negedge clk_in);
        chk({7'h0, po[0]}, {7'h0, v});
        chk({7'h0, rclk[0]}, {7'h0, ~rx[3]});
        repeat (2) @(negedge clk_in);
        chk({7'h0, cap[1]}, {7'h0, v});
        $display("test launch edge done");
    endtask
    // mid-run reset returns every register to zero, detectors back on
    task automatic t_reset;
        wreg(8'h05, 8'h3f);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(negedge clk_in);
        chk({4'h0, den, aen}, 8'h0f);
        rreg(8'h05, RX_CTRL_RESET);
        rreg(8'h16, CH_CTRL_RESET);
        $display("test reset done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_regs();
        t_det();
        t_edge(8'h09, 1'b0);
        t_edge(8'h01, 1'b1);
        t_reset();
        wrap_up();
    end
endmodule
bind lrc_bank lrc_bank_checker #(.NUM_CH(NUM_CH)) u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .cs_in(cs_in), .wr_in(wr_in), .rd_in(rd_in),
    .rack_out(rack_out), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .dlos_raw_in(dlos_raw_in), .alos_raw_in(alos_raw_in), .rec_clk_out(rec_clk_out),
    .los_out(los_out), .recovered_positive_data_out(recovered_positive_data_out),
    .dlos_det_en_out(dlos_det_en_out), .alos_det_en_out(alos_det_en_out),
    .monitor_mode_out(monitor_mode_out), .equalizer_en_out(equalizer_en_out),
    .remote_loopback_select_out(remote_loopback_select_out),
    .european_rate_select_out(european_rate_select_out));
